/* design/fcb_pkg.sv */
// Purpose: Shared constants for the flash command bus host controller.
// Assumes: 10 MHz clock, byte-wide parallel flash on the far side.
// Notes: Command codes, identifier addresses and timing counts live here.
package fcb_pkg;
  localparam int CLK_MHZ = 10;
  localparam int CLK_PERIOD_NS = 1000 / CLK_MHZ;
  // Least low time of the power-down/reset pin.
  localparam int PD_LOW_NS = 100;
  localparam int PD_LOW_CYC = (PD_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Wake time before the first command write; device value unknown here.
  localparam int WAKE_NS = 1000;
  localparam int WAKE_CYC = (WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Strobe low time and recovery for each bus cycle, in clock cycles.
  localparam int STROBE_CYC = 2;
  localparam int RECOVER_CYC = 1;
  localparam int ADDR_W = 20;
  localparam int DATA_W = 8;

  localparam logic [7:0] CMD_READ_ARRAY = 8'hff;
  localparam logic [7:0] CMD_READ_ID = 8'h90;
  localparam logic [7:0] CMD_READ_STATUS = 8'h70;
  localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h20;
  localparam logic [7:0] CMD_CONFIRM = 8'hd0;
  localparam logic [7:0] CMD_WRITE_SETUP = 8'h40;
  localparam logic [7:0] CMD_WRITE_SETUP_ALT = 8'h10;
  localparam logic [7:0] CMD_SUSPEND = 8'hb0;
  localparam logic [7:0] CMD_LOCK_SETUP = 8'h60;
  localparam logic [7:0] CMD_SET_BLOCK_LOCK = 8'h01;
  localparam logic [7:0] CMD_SET_MASTER_LOCK = 8'hf1;

  // Host operation codes on the user port.
  localparam logic [3:0] OP_READ = 4'h0;
  localparam logic [3:0] OP_READ_ARRAY = 4'h1;
  localparam logic [3:0] OP_READ_ID = 4'h2;
  localparam logic [3:0] OP_READ_STATUS = 4'h3;
  localparam logic [3:0] OP_CLEAR_STATUS = 4'h4;
  localparam logic [3:0] OP_ERASE = 4'h5;
  localparam logic [3:0] OP_BYTE_WRITE = 4'h6;
  localparam logic [3:0] OP_SUSPEND = 4'h7;
  localparam logic [3:0] OP_RESUME = 4'h8;
  localparam logic [3:0] OP_SET_BLOCK_LOCK = 4'h9;
  localparam logic [3:0] OP_SET_MASTER_LOCK = 4'ha;
  localparam logic [3:0] OP_CLEAR_LOCKS = 4'hb;
  localparam logic [3:0] OP_POWER_DOWN = 4'hc;

  localparam logic [19:0] ID_ADDR_MAKER = 20'h00000;
  localparam logic [19:0] ID_ADDR_PART = 20'h00001;
  localparam logic [15:0] ID_ADDR_BLOCK_LOW = 16'h0002;
  localparam logic [19:0] ID_ADDR_MASTER = 20'h00003;
endpackage

/* design/fcb_bus_cycle.sv */
// Purpose: One strobed bus cycle (read or write) on the flash pins.
// Assumes: Caller holds address and data steady while busy.
// Notes: Chip-select and the strobe fall and rise together.
`timescale 1ns/1ns
module fcb_bus_cycle #(
  parameter int STROBE = fcb_pkg::STROBE_CYC,
  parameter int RECOVER = fcb_pkg::RECOVER_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic is_write,
  input wire logic [7:0] data_pins_in,
  output logic busy,
  output logic done,
  output logic chip_sel_n,
  output logic out_en_n,
  output logic wr_en_n,
  output logic data_oe,
  output logic [7:0] rd_data
);
  typedef enum logic [1:0] {BC_IDLE, BC_STROBE, BC_RECOVER} fcb_bc_type;
  fcb_bc_type state_ff, nxt_state;
  logic [3:0] cnt_ff, nxt_cnt;
  logic wr_ff, nxt_wr;
  logic [7:0] rd_ff, nxt_rd;
  logic done_ff, nxt_done;

  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_wr = wr_ff;
    nxt_rd = rd_ff;
    nxt_done = 1'b0;
    case (state_ff)
      BC_IDLE: begin
        if (start) begin
          nxt_state = BC_STROBE;
          nxt_cnt = 4'(STROBE - 1);
          nxt_wr = is_write;
        end
      end
      BC_STROBE: begin
        if (cnt_ff == 4'h0) begin
          // Data is sampled before the strobe rises, while still driven.
          if (!wr_ff) nxt_rd = data_pins_in;
          nxt_state = BC_RECOVER;
          nxt_cnt = 4'(RECOVER - 1);
        end else begin
          nxt_cnt = cnt_ff - 4'h1;
        end
      end
      BC_RECOVER: begin
        if (cnt_ff == 4'h0) begin
          nxt_state = BC_IDLE;
          nxt_done = 1'b1;
        end else begin
          nxt_cnt = cnt_ff - 4'h1;
        end
      end
      default: nxt_state = BC_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_ff <= BC_IDLE;
      cnt_ff <= 4'h0;
      wr_ff <= 1'b0;
      rd_ff <= 8'h00;
      done_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      wr_ff <= nxt_wr;
      rd_ff <= nxt_rd;
      done_ff <= nxt_done;
    end
  end

  // Both edges rise together, so the device latches on either one.
  assign chip_sel_n = (state_ff != BC_STROBE);
  // Output-enable and write-enable are never low together.
  assign out_en_n = !(state_ff == BC_STROBE && !wr_ff);
  assign wr_en_n = !(state_ff == BC_STROBE && wr_ff);
  assign data_oe = (state_ff == BC_STROBE) && wr_ff;
  assign busy = (state_ff != BC_IDLE);
  assign done = done_ff;
  assign rd_data = rd_ff;
endmodule

/* design/fcb_host.sv */
// Purpose: Host controller that drives a byte-wide flash through its pins.
// Assumes: Device pins are synchronous to clk; one request at a time.
// Notes: Translates user operations into command write sequences.
`timescale 1ns/1ns
module fcb_host #(
  parameter int WAKE_CYCLES = fcb_pkg::WAKE_CYC,
  parameter int PD_CYCLES = fcb_pkg::PD_LOW_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic [3:0] req_op,
  input wire logic [19:0] req_addr,
  input wire logic [7:0] req_data,
  input wire logic req_high_voltage,
  output logic resp_valid,
  output logic [7:0] resp_data,
  output logic flash_ready,
  output logic [19:0] addr_pins,
  output logic [7:0] data_pins_out,
  output logic data_pins_oe,
  input wire logic [7:0] data_pins_in,
  output logic chip_sel_n,
  output logic out_en_n,
  output logic wr_en_n,
  output logic powerdown_reset_n,
  output logic reset_high_voltage,
  input wire logic ready_busy_out
);
  typedef enum logic [2:0] {
    HS_PD, HS_WAKE, HS_IDLE, HS_CYC1, HS_CYC2, HS_RESP
  } fcb_hs_type;
  fcb_hs_type state_ff, nxt_state;
  logic [15:0] cnt_ff, nxt_cnt;
  logic [19:0] addr_ff, nxt_addr;
  logic [7:0] d1_ff, nxt_d1;
  logic [7:0] d2_ff, nxt_d2;
  logic two_ff, nxt_two;
  logic rd2_ff, nxt_rd2;
  logic hv_ff, nxt_hv;
  logic [7:0] resp_ff, nxt_resp;
  logic rv_ff, nxt_rv;
  logic [7:0] dout_ff, nxt_dout;
  logic bc_start, bc_write, bc_busy, bc_done;
  logic [7:0] bc_rd;

  // First command byte for an operation; OP_READ issues no command.
  function automatic logic [7:0] first_cmd(input logic [3:0] op);
    case (op)
      fcb_pkg::OP_READ_ARRAY: first_cmd = fcb_pkg::CMD_READ_ARRAY;
      fcb_pkg::OP_READ_ID: first_cmd = fcb_pkg::CMD_READ_ID;
      fcb_pkg::OP_READ_STATUS: first_cmd = fcb_pkg::CMD_READ_STATUS;
      fcb_pkg::OP_CLEAR_STATUS: first_cmd = fcb_pkg::CMD_CLEAR_STATUS;
      fcb_pkg::OP_ERASE: first_cmd = fcb_pkg::CMD_ERASE_SETUP;
      fcb_pkg::OP_BYTE_WRITE: first_cmd = fcb_pkg::CMD_WRITE_SETUP;
      fcb_pkg::OP_SUSPEND: first_cmd = fcb_pkg::CMD_SUSPEND;
      fcb_pkg::OP_RESUME: first_cmd = fcb_pkg::CMD_CONFIRM;
      default: first_cmd = fcb_pkg::CMD_LOCK_SETUP;
    endcase
  endfunction

  // Second write byte; the byte write carries the user's data.
  function automatic logic [7:0] second_cmd(input logic [3:0] op,
                                            input logic [7:0] d);
    case (op)
      fcb_pkg::OP_BYTE_WRITE: second_cmd = d;
      fcb_pkg::OP_SET_BLOCK_LOCK:
        second_cmd = fcb_pkg::CMD_SET_BLOCK_LOCK;
      fcb_pkg::OP_SET_MASTER_LOCK:
        second_cmd = fcb_pkg::CMD_SET_MASTER_LOCK;
      default: second_cmd = fcb_pkg::CMD_CONFIRM;
    endcase
  endfunction

  function automatic logic is_two_write(input logic [3:0] op);
    is_two_write = (op == fcb_pkg::OP_ERASE) ||
                   (op == fcb_pkg::OP_BYTE_WRITE) ||
                   (op == fcb_pkg::OP_SET_BLOCK_LOCK) ||
                   (op == fcb_pkg::OP_SET_MASTER_LOCK) ||
                   (op == fcb_pkg::OP_CLEAR_LOCKS);
  endfunction

  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_addr = addr_ff;
    nxt_d1 = d1_ff;
    nxt_d2 = d2_ff;
    nxt_two = two_ff;
    nxt_rd2 = rd2_ff;
    nxt_hv = hv_ff;
    nxt_resp = resp_ff;
    nxt_rv = 1'b0;
    nxt_dout = dout_ff;
    bc_start = 1'b0;
    bc_write = 1'b0;
    case (state_ff)
      HS_PD: begin
        // Reset pin is held low for the full minimum time.
        if (cnt_ff == 16'h0) begin
          nxt_state = HS_WAKE;
          nxt_cnt = 16'(WAKE_CYCLES - 1);
        end else begin
          nxt_cnt = cnt_ff - 16'h1;
        end
      end
      HS_WAKE: begin
        // No command goes out until the wake interval has passed.
        if (cnt_ff == 16'h0) nxt_state = HS_IDLE;
        else nxt_cnt = cnt_ff - 16'h1;
      end
      HS_IDLE: begin
        nxt_hv = 1'b0;
        if (req_valid) begin
          nxt_addr = req_addr;
          nxt_d1 = first_cmd(req_op);
          nxt_d2 = second_cmd(req_op, req_data);
          nxt_two = is_two_write(req_op);
          nxt_rd2 = (req_op == fcb_pkg::OP_READ);
          // High voltage is raised only for lock-sensitive operations.
          nxt_hv = req_high_voltage && is_two_write(req_op);
          if (req_op == fcb_pkg::OP_POWER_DOWN) begin
            nxt_state = HS_PD;
            nxt_cnt = 16'(PD_CYCLES - 1);
          end else if (req_op > fcb_pkg::OP_POWER_DOWN) begin
            // Undefined codes are answered without a bus cycle; the address pins still load req_addr.
            nxt_state = HS_RESP;
            nxt_resp = 8'h00;
          end else begin
            nxt_state = HS_CYC1;
          end
        end
      end
      HS_CYC1: begin
        if (!bc_busy && !bc_done) begin
          bc_start = 1'b1;
          bc_write = !rd2_ff;
          nxt_dout = d1_ff;
        end else if (bc_done) begin
          if (rd2_ff) begin
            nxt_resp = bc_rd;
            nxt_state = HS_RESP;
          end else if (two_ff) begin
            nxt_state = HS_CYC2;
          end else begin
            nxt_resp = 8'h00;
            nxt_state = HS_RESP;
          end
        end
      end
      HS_CYC2: begin
        if (!bc_busy && !bc_done) begin
          bc_start = 1'b1;
          bc_write = 1'b1;
          nxt_dout = d2_ff;
        end else if (bc_done) begin
          nxt_resp = 8'h00;
          nxt_state = HS_RESP;
        end
      end
      HS_RESP: begin
        nxt_rv = 1'b1;
        // High voltage is gone before the controller can take a new order.
        nxt_hv = 1'b0;
        nxt_state = HS_IDLE;
      end
      default: nxt_state = HS_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      // Reset starts a power-down pulse so the device is in a known mode.
      state_ff <= HS_PD;
      cnt_ff <= 16'(PD_CYCLES - 1);
      addr_ff <= 20'h00000;
      d1_ff <= 8'h00;
      d2_ff <= 8'h00;
      two_ff <= 1'b0;
      rd2_ff <= 1'b0;
      hv_ff <= 1'b0;
      resp_ff <= 8'h00;
      rv_ff <= 1'b0;
      dout_ff <= 8'h00;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      addr_ff <= nxt_addr;
      d1_ff <= nxt_d1;
      d2_ff <= nxt_d2;
      two_ff <= nxt_two;
      rd2_ff <= nxt_rd2;
      hv_ff <= nxt_hv;
      resp_ff <= nxt_resp;
      rv_ff <= nxt_rv;
      dout_ff <= nxt_dout;
    end
  end

  // Each read is its own strobe, so status reads always see a fresh latch.
  fcb_bus_cycle u_cycle (
    .clk(clk),
    .rst_n(rst_n),
    .start(bc_start),
    .is_write(bc_write),
    .data_pins_in(data_pins_in),
    .busy(bc_busy),
    .done(bc_done),
    .chip_sel_n(chip_sel_n),
    .out_en_n(out_en_n),
    .wr_en_n(wr_en_n),
    .data_oe(data_pins_oe),
    .rd_data(bc_rd)
  );

  assign req_ready = (state_ff == HS_IDLE);
  assign resp_valid = rv_ff;
  assign resp_data = resp_ff;
  assign addr_pins = addr_ff;
  assign data_pins_out = dout_ff;
  assign powerdown_reset_n = (state_ff != HS_PD);
  assign reset_high_voltage = hv_ff && (state_ff != HS_PD);
  assign flash_ready = ready_busy_out;
endmodule

/* tb/fcb_sva.sv */
// Purpose: Pin timing checks on the flash host controller.
// Assumes: Bound to fcb_host; one clock domain.
// Notes: Counters track how long the power-down pin sat low or high.
`timescale 1ns/1ns
module fcb_sva #(
  parameter int WAKE_CYCLES = 10,
  parameter int PD_CYCLES = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic req_valid,
  input wire logic req_ready,
  input wire logic [3:0] req_op,
  input wire logic [19:0] addr_pins,
  input wire logic [7:0] data_pins_out,
  input wire logic data_pins_oe,
  input wire logic chip_sel_n,
  input wire logic out_en_n,
  input wire logic wr_en_n,
  input wire logic powerdown_reset_n,
  input wire logic reset_high_voltage,
  input wire logic flash_ready,
  input wire logic ready_busy_out
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  int up_ff = 0;
  int lo_ff = 0;
  int nxt_up;
  int nxt_lo;
  // Both counters saturate so a long run cannot wrap them.
  always_comb begin
    nxt_up = powerdown_reset_n ? (up_ff > 999 ? up_ff : up_ff + 1) : 0;
    nxt_lo = powerdown_reset_n ? 0 : (lo_ff > 999 ? lo_ff : lo_ff + 1);
  end
  // Cleared in reset so an unknown pin level at start cannot stick here.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      up_ff <= 0;
      lo_ff <= 0;
    end else begin
      up_ff <= nxt_up;
      lo_ff <= nxt_lo;
    end
  end
  // Write data is loaded on the edge that opens the strobe, so it is
  // compared only from the second strobe cycle on.
  sequence s_wr;
    (!wr_en_n && !chip_sel_n && data_pins_oe)
      ##1 (!wr_en_n && !chip_sel_n && data_pins_oe
      && $stable(data_pins_out) && $stable(addr_pins))
      ##1 (wr_en_n && chip_sel_n);
  endsequence
  sequence s_rd;
    (!out_en_n && !chip_sel_n && !data_pins_oe && wr_en_n)[*2] ##1 out_en_n;
  endsequence
  property p_wr; $fell(wr_en_n) |-> s_wr; endproperty
  a_wr: assert property (p_wr) else $error("bad write strobe");
  property p_rd; $fell(out_en_n) |-> s_rd; endproperty
  a_rd: assert property (p_rd) else $error("bad read strobe");
  property p_oe_we; !(!out_en_n && !wr_en_n); endproperty
  a_oe_we: assert property (p_oe_we) else $error("both strobes low");
  property p_pd; $rose(powerdown_reset_n) |-> lo_ff >= PD_CYCLES; endproperty
  a_pd: assert property (p_pd) else $error("power-down too short");
  property p_wake; $fell(wr_en_n) |-> up_ff >= WAKE_CYCLES; endproperty
  a_wake: assert property (p_wake) else $error("write before wake");
  property p_refuse;
    req_valid && req_ready && req_op > 4'hc
      |=> (chip_sel_n && powerdown_reset_n)[*3];
  endproperty
  a_refuse: assert property (p_refuse) else $error("bus use on bad op");
  property p_hv;
    reset_high_voltage |-> powerdown_reset_n && !req_ready;
  endproperty
  a_hv: assert property (p_hv) else $error("high level while low");
  property p_busy; flash_ready == ready_busy_out; endproperty
  a_busy: assert property (p_busy) else $error("busy not passed");
endmodule

bind fcb_host fcb_sva #(.WAKE_CYCLES(WAKE_CYCLES), .PD_CYCLES(PD_CYCLES))
  sva_u (.clk(clk), .rst_n(rst_n), .req_valid(req_valid),
  .req_ready(req_ready), .req_op(req_op), .addr_pins(addr_pins),
  .data_pins_out(data_pins_out), .data_pins_oe(data_pins_oe),
  .chip_sel_n(chip_sel_n), .out_en_n(out_en_n), .wr_en_n(wr_en_n),
  .powerdown_reset_n(powerdown_reset_n), .flash_ready(flash_ready),
  .reset_high_voltage(reset_high_voltage), .ready_busy_out(ready_busy_out));

/* tb/fcb_flash_model.sv */
// Purpose: Behavioural byte-wide flash for the host controller bench.
// Assumes: Pins come from fcb_host; busy time counted in clk cycles.
// Notes: Undriven data shows the inverse byte so a float is never missed.
`timescale 1ns/1ns
module fcb_flash_model #(
  parameter logic [7:0] MAKER = 8'h5a,
  parameter logic [7:0] PART = 8'h3c,
  parameter int BUSY_CYC = 60
) (
  input wire logic clk,
  input wire logic vpp_high,
  input wire logic [19:0] addr_pins,
  input wire logic [7:0] data_pins_out,
  input wire logic chip_sel_n,
  input wire logic out_en_n,
  input wire logic wr_en_n,
  input wire logic powerdown_reset_n,
  input wire logic reset_high_voltage,
  output logic [7:0] data_pins_in,
  output logic ready_busy_out
);
  logic [7:0] mem [int];
  logic [15:0] blk_lk = 16'h0000;
  logic mst_lk = 1'b0;
  logic susp = 1'b0;
  logic [5:0] err = 6'h00;
  logic [7:0] pend = 8'h00;
  logic [7:0] rv = 8'h00;
  logic [1:0] mode = 2'h0;
  int busy = 0;
  wire wr_act = !chip_sel_n && !wr_en_n && powerdown_reset_n;
  wire rd_act = !chip_sel_n && !out_en_n && powerdown_reset_n;
  assign ready_busy_out = busy == 0 || susp || !powerdown_reset_n;
  assign data_pins_in = rd_act ? rv : ~rv;
  function automatic logic go(input logic [5:0] t, input logic lk);
    mode = 2'h2;
    if (!vpp_high || (lk && !reset_high_voltage)) begin
      err = err | t | (vpp_high ? 6'h02 : 6'h08);
      return 1'b0;
    end
    busy = BUSY_CYC;
    return 1'b1;
  endfunction
  always @(posedge clk) begin
    if (!powerdown_reset_n) begin
      busy = 0;
      susp = 1'b0;
      mode = 2'h0;
      err = 6'h00;
      pend = 8'h00;
    end else if (busy > 0 && !susp) begin
      busy = busy - 1;
    end
  end
  always @(negedge wr_act) begin
    logic [7:0] c;
    logic [7:0] p;
    logic [3:0] b;
    int k;
    c = data_pins_out;
    p = pend;
    b = addr_pins[19:16];
    pend = 8'h00;
    if (powerdown_reset_n !== 1'b1) begin
    end else if (p == 8'h20 && c == 8'hd0) begin
      if (go(6'h20, blk_lk[b]) && mem.first(k)) begin
        do begin
          if (k[19:16] == b) mem[k] = 8'hff;
        end while (mem.next(k));
      end
    end else if (p == 8'h40 || p == 8'h10) begin
      if (go(6'h10, blk_lk[b]))
        mem[addr_pins] = (mem.exists(addr_pins) ? mem[addr_pins] : 8'hff) & c;
    end else if (p == 8'h60 && c == 8'h01) begin
      if (go(6'h10, mst_lk)) blk_lk[b] = 1'b1;
    end else if (p == 8'h60 && c == 8'hf1) begin
      if (go(6'h10, 1'b1)) mst_lk = 1'b1;
    end else if (p == 8'h60 && c == 8'hd0) begin
      if (go(6'h20, mst_lk)) blk_lk = 16'h0000;
    end else if (p != 8'h00) begin
      err = err | 6'h30;
      mode = 2'h2;
    end else begin
      case (c)
        8'hff: mode = 2'h0;
        8'h90: mode = 2'h1;
        8'h70: mode = 2'h2;
        8'h50: err = 6'h00;
        8'hb0: susp = busy > 0;
        8'hd0: susp = 1'b0;
        default: pend = c;
      endcase
    end
  end
  always @(posedge rd_act) begin
    if (mode == 2'h2) rv = {busy == 0 || susp, susp, err};
    else if (mode == 2'h0) rv = mem.exists(addr_pins) ? mem[addr_pins] : 8'hff;
    else if (addr_pins[15:0] == 16'h0002) rv = {7'h00, blk_lk[addr_pins[19:16]]};
    else rv = addr_pins == 20'h0 ? MAKER : addr_pins == 20'h1 ? PART : mst_lk;
  end
endmodule

/* tb/flash_command_bus_interface_bench.sv */
// Purpose: Self-checking bench for the flash host controller.
// Assumes: Behavioural flash model on the far side.
// Notes: A short wake count keeps the run brief.
`timescale 1ns/1ns
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin errors++; \
  $display("[FAIL] %0t got %h exp %h", $time, a, e); end end
module flash_command_bus_interface_bench;
  localparam logic [7:0] MK = 8'h5a; // Arbitrary maker code.
  localparam logic [7:0] PT = 8'h3c; // Arbitrary part code.
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic req_valid = 1'b0;
  logic hv = 1'b0;
  logic vpp_high = 1'b1;
  logic [3:0] req_op = 4'h0;
  logic [19:0] req_addr = 20'h00000;
  logic [7:0] req_data = 8'h00;
  logic req_ready, resp_valid, flash_ready, oe, cs_n, oe_n, we_n, pd_n;
  logic rhv, rdy;
  logic [19:0] ap;
  logic [7:0] resp_data, dout, din;
  int errors = 0;
  int n_checks = 0;
  always #50 clk = ~clk;
  fcb_host #(.WAKE_CYCLES(3)) dut_u (.clk(clk), .rst_n(rst_n),
    .req_valid(req_valid), .req_ready(req_ready), .req_op(req_op),
    .req_addr(req_addr), .req_data(req_data), .req_high_voltage(hv),
    .resp_valid(resp_valid), .resp_data(resp_data), .flash_ready(flash_ready),
    .addr_pins(ap), .data_pins_out(dout), .data_pins_oe(oe),
    .data_pins_in(din), .chip_sel_n(cs_n), .out_en_n(oe_n), .wr_en_n(we_n),
    .powerdown_reset_n(pd_n), .reset_high_voltage(rhv), .ready_busy_out(rdy));
  fcb_flash_model #(.MAKER(MK), .PART(PT)) fl_u (.clk(clk),
    .vpp_high(vpp_high), .addr_pins(ap), .data_pins_out(dout),
    .chip_sel_n(cs_n), .out_en_n(oe_n), .wr_en_n(we_n), .powerdown_reset_n(pd_n),
    .reset_high_voltage(rhv), .data_pins_in(din), .ready_busy_out(rdy));
  task automatic wrap_up();
    if (errors == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic bail(input int n);
    if (n >= 3000) begin
      errors++;
      wrap_up();
    end
  endtask
  task automatic op(input logic [3:0] o, input logic [19:0] a,
      input logic [7:0] d, input logic h);
    int n;
    n = 0;
    while (req_ready !== 1'b1 && n < 3000) begin @(posedge clk); #1 n++; end
    bail(n);
    req_valid = 1'b1;
    req_op = o;
    req_addr = a;
    req_data = d;
    hv = h;
    @(posedge clk);
    #1 req_valid = 1'b0;
    n = 0;
    while (o != fcb_pkg::OP_POWER_DOWN && resp_valid !== 1'b1 && n < 3000)
      begin @(posedge clk); #1 n++; end
    bail(n);
  endtask
  task automatic rdc(input logic [19:0] a, input logic [7:0] e);
    op(fcb_pkg::OP_READ, a, 8'h00, 1'b0);
    `CHK(resp_data, e)
  endtask
  task automatic idle();
    int n;
    n = 0;
    while (flash_ready !== 1'b1 && n < 3000) begin @(posedge clk); #1 n++; end
    bail(n);
  endtask
  task automatic t_ident();
    op(fcb_pkg::OP_READ_ID, 20'h0, 8'h00, 1'b0);
    rdc(20'h00000, MK);
    rdc(20'h00001, PT);
    rdc(20'h30002, 8'h00);
  endtask
  task automatic t_write();
    op(fcb_pkg::OP_BYTE_WRITE, 20'h10005, 8'h5a, 1'b0);
    idle();
    rdc(20'h10005, 8'h80);
    op(fcb_pkg::OP_READ_ARRAY, 20'h0, 8'h00, 1'b0);
    rdc(20'h10005, 8'h5a);
    vpp_high = 1'b0;
    op(fcb_pkg::OP_BYTE_WRITE, 20'h10006, 8'h00, 1'b0);
    rdc(20'h0, 8'h98);
    vpp_high = 1'b1;
    op(fcb_pkg::OP_CLEAR_STATUS, 20'h0, 8'h00, 1'b0);
    op(fcb_pkg::OP_READ_STATUS, 20'h0, 8'h00, 1'b0);
    rdc(20'h0, 8'h80);
  endtask
  task automatic t_lock();
    op(fcb_pkg::OP_SET_BLOCK_LOCK, 20'h20000, 8'h00, 1'b0);
    idle();
    op(fcb_pkg::OP_BYTE_WRITE, 20'h20001, 8'h00, 1'b0);
    rdc(20'h0, 8'h92);
    op(fcb_pkg::OP_CLEAR_STATUS, 20'h0, 8'h00, 1'b0);
    op(fcb_pkg::OP_BYTE_WRITE, 20'h20001, 8'h00, 1'b1);
    idle();
    op(fcb_pkg::OP_ERASE, 20'h20000, 8'h00, 1'b1);
    idle();
    op(fcb_pkg::OP_READ_ARRAY, 20'h0, 8'h00, 1'b0);
    rdc(20'h20001, 8'hff);
    op(fcb_pkg::OP_SET_MASTER_LOCK, 20'h0, 8'h00, 1'b0);
    rdc(20'h0, 8'h92);
    op(fcb_pkg::OP_SET_MASTER_LOCK, 20'h0, 8'h00, 1'b1);
    idle();
    op(fcb_pkg::OP_CLEAR_STATUS, 20'h0, 8'h00, 1'b0);
    op(fcb_pkg::OP_CLEAR_LOCKS, 20'h0, 8'h00, 1'b0);
    rdc(20'h0, 8'ha2);
    op(fcb_pkg::OP_CLEAR_LOCKS, 20'h0, 8'h00, 1'b1);
    idle();
    op(fcb_pkg::OP_READ_ID, 20'h0, 8'h00, 1'b0);
    rdc(20'h20002, 8'h00);
    rdc(20'h00003, 8'h01);
  endtask
  task automatic t_susp();
    op(fcb_pkg::OP_ERASE, 20'h50000, 8'h00, 1'b0);
    `CHK(flash_ready, 1'b0)
    op(fcb_pkg::OP_SUSPEND, 20'h0, 8'h00, 1'b0);
    `CHK(flash_ready, 1'b1)
    op(fcb_pkg::OP_RESUME, 20'h0, 8'h00, 1'b0);
    `CHK(flash_ready, 1'b0)
  endtask
  task automatic t_pd();
    op(fcb_pkg::OP_POWER_DOWN, 20'h0, 8'h00, 1'b0);
    rdc(20'h10005, 8'h5a);
    op(fcb_pkg::OP_READ_STATUS, 20'h0, 8'h00, 1'b0);
    rdc(20'h0, 8'h80);
    op(4'hd, 20'h0, 8'h00, 1'b0);
    `CHK(resp_data, 8'h00)
  endtask
  initial begin
    repeat (6) @(posedge clk);
    #1 rst_n = 1'b1;
    t_ident();
    t_write();
    t_lock();
    t_susp();
    t_pd();
    wrap_up();
  end
endmodule
